// File: rtl/bfcfg_pkg.sv
// bfcfg_pkg: constants shared by the burst read configuration block
// assumes: 32-bit classic wishbone register port, 8-bit configuration word
package bfcfg_pkg;
  // configuration word: command address bits 19..12 mapped to bits 7..0
  localparam int CMD_LSB = 12;
  localparam int CFG_W = 8;
  localparam int MODE_BIT = 7;
  localparam int RDY_BIT = 6;
  localparam int EDGE_BIT = 5;
  localparam int BL_HI = 4;
  localparam int BL_LO = 3;
  localparam int LAT_HI = 2;
  localparam int LAT_LO = 0;
  // async, rdy with data, rising edge, continuous, latency code 101
  localparam logic [7:0] CFG_RST = 8'he5;
  localparam logic [1:0] BL_CONT = 2'h0;
  localparam logic [1:0] BL_8 = 2'h1;
  localparam logic [1:0] BL_16 = 2'h2;
  // low address bits that wrap in the 8, 16 and 32 word modes
  localparam logic [7:0] WRAP_8 = 8'h07;
  localparam logic [7:0] WRAP_16 = 8'h0f;
  localparam logic [7:0] WRAP_32 = 8'h1f;
  localparam logic [2:0] LAT_MIN = 3'h0;
  localparam logic [2:0] LAT_MAX = 3'h5;
  // first valid edge is latency code plus this base
  localparam logic [3:0] LAT_BASE = 4'h2;
  localparam logic [3:0] EDGE_ONE = 4'h1;
  // register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam int STAT_BUSY = 0;
  localparam int STAT_RSVD = 1;
  localparam int STAT_PEND = 2;
  localparam int STAT_SYNC = 3;
  localparam int ADR_W = 8;
  typedef enum logic [1:0] {
    BFCFG_IDLE  = 2'b00,
    BFCFG_LAT   = 2'b01,
    BFCFG_BURST = 2'b11
  } bfcfg_state_t;
endpackage

// File: rtl/bfcfg_word_if.sv
// bfcfg_word_if: word transfer between a user and a clock crossing
// assumes: user side and core share the source clock for ld/busy
`timescale 1ns/1ps
`default_nettype none
interface bfcfg_word_if #(parameter int W = 8);
  logic         ld;
  logic [W-1:0] wdata;
  logic         busy;
  logic [W-1:0] rdata;
  logic         stb;
  modport core (input ld, input wdata, output busy, output rdata, output stb);
  modport user (output ld, output wdata, input busy, input rdata, input stb);
endinterface
`default_nettype wire

// File: rtl/bfcfg_sync.sv
// bfcfg_sync: two flip-flop level synchroniser
// assumes: d_i is a level from a foreign clock domain
`timescale 1ns/1ps
`default_nettype none
module bfcfg_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
    end
  end

  assign q_o = s2_r;
endmodule // bfcfg_sync
`default_nettype wire

// File: rtl/bfcfg_xfer.sv
// bfcfg_xfer: toggle handshake word crossing, newest word wins
// assumes: each side reset by its own synchronous reset
`timescale 1ns/1ps
`default_nettype none
module bfcfg_xfer #(
  parameter int W = 8
) (
  input wire logic   src_clk_i,
  input wire logic   src_rst_i,
  input wire logic   dst_clk_i,
  input wire logic   dst_rst_i,
  bfcfg_word_if.core w
);
  logic [W-1:0] hold_r;
  logic [W-1:0] pend_r;
  logic [W-1:0] rdata_r;
  logic         pend_v_r;
  logic         tog_r;
  logic         ack_r;
  logic         stb_r;
  logic [1:0]   tsync_r;
  logic [1:0]   async_r;
  logic         inflight;
  logic         send;

  assign inflight = tog_r ^ async_r[1];
  assign send = pend_v_r & ~inflight;

  always_ff @(posedge src_clk_i) begin
    if (src_rst_i) begin
      pend_r <= '0;
      pend_v_r <= 1'b0;
    end else if (w.ld) begin
      pend_r <= w.wdata;
      pend_v_r <= 1'b1;
    end else if (send) begin
      pend_v_r <= 1'b0;
    end
  end

  // hold_r stays still until the far side has echoed the toggle
  always_ff @(posedge src_clk_i) begin
    if (src_rst_i) begin
      hold_r <= '0;
      tog_r <= 1'b0;
      async_r <= 2'b00;
    end else begin
      async_r <= {async_r[0], ack_r};
      if (send) begin
        hold_r <= pend_r;
        tog_r <= ~tog_r;
      end
    end
  end

  always_ff @(posedge dst_clk_i) begin
    if (dst_rst_i) begin
      tsync_r <= 2'b00;
      ack_r <= 1'b0;
      rdata_r <= '0;
      stb_r <= 1'b0;
    end else begin
      tsync_r <= {tsync_r[0], tog_r};
      ack_r <= tsync_r[1];
      stb_r <= tsync_r[1] ^ ack_r;
      if (tsync_r[1] ^ ack_r) begin
        rdata_r <= hold_r;
      end
    end
  end

  assign w.busy = pend_v_r | inflight;
  assign w.rdata = rdata_r;
  assign w.stb = stb_r;
endmodule // bfcfg_xfer
`default_nettype wire

// File: rtl/bfcfg_top.sv
// bfcfg_top: burst read configuration register and burst timing
// assumes: flash bus signals are synchronous to link_clk_i
// Operation
// - config bit 19 low selects synchronous burst reads; high, the default, asynchronous
// - bit 18 low: ready one cycle before data, except at latency code 0; high, default: ready with data
// - bit 17 selects falling or rising active clock edge; rising is default
// - bits 16:15 pick continuous, or 8, 16, 32 word wrapped burst
// - bits 14:12 codes 0..5 give first data on edges 2..7 after strobe rises
// - power-up and hardware reset restore every field to its default
// - default latency code is 101, first data on edge 7
`timescale 1ns/1ps
`default_nettype none
module bfcfg_top
  import bfcfg_pkg::*;
#(
  parameter int ADDR_W = 22
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              link_clk_i,
  input  wire logic              cfg_cmd_i,
  input  wire logic [19:12]      cfg_addr_i,
  input  wire logic              chip_en_n_i,
  input  wire logic              addr_valid_strobe_n_i,
  input  wire logic [ADDR_W-1:0] link_addr_i,
  output logic                   rdy_o,
  output logic                   data_valid_o,
  output logic      [ADDR_W-1:0] word_addr_o
);
  logic [CFG_W-1:0]  cfg_r;
  logic [CFG_W-1:0]  lcfg_r;
  logic              lrst;
  logic              wb_req;
  logic              wb_hit_cfg;
  logic              wb_wr_cfg;
  logic              ack_r;
  logic [31:0]       rdat_r;
  logic              busy_sys;
  logic [CFG_W-1:0]  cfg_nxt;
  logic              cfg_ld;
  bfcfg_state_t      st_r;
  logic [3:0]        cnt_r;
  logic [3:0]        edge_n;
  logic [3:0]        tgt_dv;
  logic [3:0]        tgt_rdy;
  logic              avd_q_r;
  logic              start;
  logic              rdy_r;
  logic              dv_r;
  logic [ADDR_W-1:0] ptr_r;
  logic [ADDR_W-1:0] ptr_nxt;
  logic [ADDR_W-1:0] wmask;
  logic              rdy_f_r;
  logic              dv_f_r;
  logic [ADDR_W-1:0] ptr_f_r;
  logic [2:0]        lat;
  logic [1:0]        bl;
  logic              busy_l;
  logic [3:0]        dv_at_r;
  logic [3:0]        rdy_at_r;
  logic [1:0]        bl_at_r;

  bfcfg_word_if #(.W(CFG_W)) up_w ();
  bfcfg_word_if #(.W(CFG_W)) dn_w ();

  // link reset follows hardware reset into the link domain
  bfcfg_sync #(.W(1)) u_lrst (
    .clk_i (link_clk_i),
    .rst_i (1'b0),
    .d_i   (rst_i),
    .q_o   (lrst)
  );

  bfcfg_sync #(.W(1)) u_busy (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (busy_l),
    .q_o   (busy_sys)
  );

  // configuration command from the flash bus, link to system
  bfcfg_xfer #(.W(CFG_W)) u_up (
    .src_clk_i (link_clk_i),
    .src_rst_i (lrst),
    .dst_clk_i (clk_i),
    .dst_rst_i (rst_i),
    .w         (up_w)
  );

  // effective configuration, system to link
  bfcfg_xfer #(.W(CFG_W)) u_dn (
    .src_clk_i (clk_i),
    .src_rst_i (rst_i),
    .dst_clk_i (link_clk_i),
    .dst_rst_i (lrst),
    .w         (dn_w)
  );

  assign up_w.ld = cfg_cmd_i;
  assign up_w.wdata = cfg_addr_i;

  // ---------------- wishbone slave ----------------
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wb_hit_cfg = wb_adr_i == OFS_CFG;
  assign wb_wr_cfg = wb_req & wb_we_i & wb_hit_cfg & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_r <= '0;
    end else if (wb_req) begin
      rdat_r <= '0;
      if (!wb_we_i && wb_hit_cfg) begin
        rdat_r[CFG_W-1:0] <= cfg_r;
      end else if (!wb_we_i && wb_adr_i == OFS_STAT) begin
        rdat_r[STAT_BUSY] <= busy_sys;
        rdat_r[STAT_RSVD] <= cfg_r[LAT_HI:LAT_LO] > LAT_MAX;
        rdat_r[STAT_PEND] <= dn_w.busy;
        rdat_r[STAT_SYNC] <= ~cfg_r[MODE_BIT];
      end
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdat_r;

  // ---------------- configuration register ----------------
  // a flash bus command in the same cycle as a bus write wins
  always_comb begin
    cfg_nxt = cfg_r;
    cfg_ld = 1'b0;
    if (up_w.stb) begin
      cfg_nxt = up_w.rdata;
      cfg_ld = 1'b1;
    end else if (wb_wr_cfg) begin
      cfg_nxt = wb_dat_i[CFG_W-1:0];
      cfg_ld = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg_r <= CFG_RST;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  assign dn_w.ld = cfg_ld;
  assign dn_w.wdata = cfg_nxt;

  // link copy, defaults again on every reset
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      lcfg_r <= CFG_RST;
    end else if (dn_w.stb) begin
      lcfg_r <= dn_w.rdata;
    end
  end

  // ---------------- burst timing, link domain ----------------
  assign lat = lcfg_r[LAT_HI:LAT_LO];
  assign bl = lcfg_r[BL_HI:BL_LO];
  // data sampled on edge lat+2, so presented after edge lat+1
  assign tgt_dv = {1'b0, lat} + LAT_BASE - EDGE_ONE;
  // early ready is meaningless at the shortest latency
  assign tgt_rdy = (!lcfg_r[RDY_BIT] && lat != LAT_MIN) ?
                   tgt_dv - EDGE_ONE : tgt_dv;
  // a rising strobe in sync mode starts the count at edge one
  assign start = !avd_q_r && addr_valid_strobe_n_i && !chip_en_n_i &&
                 !lcfg_r[MODE_BIT];
  assign edge_n = cnt_r + EDGE_ONE;

  always_comb begin
    case (bl_at_r)
      BL_CONT: wmask = '1;
      BL_8:    wmask = ADDR_W'(WRAP_8);
      BL_16:   wmask = ADDR_W'(WRAP_16);
      default: wmask = ADDR_W'(WRAP_32);
    endcase
  end

  // wrapped bursts stay inside their aligned block
  assign ptr_nxt = (ptr_r & ~wmask) | ((ptr_r + 1'b1) & wmask);

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      avd_q_r <= 1'b1;
    end else begin
      avd_q_r <= addr_valid_strobe_n_i;
    end
  end

  // latency, ready and wrap timing frozen at start; mode and edge bits still act mid-burst
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      dv_at_r <= '0;
      rdy_at_r <= '0;
      bl_at_r <= BL_CONT;
    end else if (start) begin
      dv_at_r <= tgt_dv;
      rdy_at_r <= tgt_rdy;
      bl_at_r <= bl;
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      st_r <= BFCFG_IDLE;
      cnt_r <= '0;
      rdy_r <= 1'b0;
      dv_r <= 1'b0;
    end else if (!addr_valid_strobe_n_i || chip_en_n_i) begin
      st_r <= BFCFG_IDLE;
      cnt_r <= '0;
      rdy_r <= 1'b0;
      dv_r <= 1'b0;
    end else begin
      case (st_r)
        BFCFG_IDLE: begin
          if (start) begin
            cnt_r <= EDGE_ONE;
            rdy_r <= tgt_rdy == EDGE_ONE;
            dv_r <= tgt_dv == EDGE_ONE;
            st_r <= (tgt_dv == EDGE_ONE) ? BFCFG_BURST : BFCFG_LAT;
          end
        end
        BFCFG_LAT: begin
          cnt_r <= edge_n;
          if (edge_n == rdy_at_r) begin
            rdy_r <= 1'b1;
          end
          if (edge_n == dv_at_r) begin
            dv_r <= 1'b1;
            st_r <= BFCFG_BURST;
          end
        end
        BFCFG_BURST: begin
          rdy_r <= 1'b1;
          dv_r <= 1'b1;
        end
        default: begin
          st_r <= BFCFG_IDLE;
        end
      endcase
    end
  end

  // address captured while the strobe is low, advanced per data edge
  always_ff @(posedge link_clk_i) begin
    if (lrst) begin
      ptr_r <= '0;
    end else if (!addr_valid_strobe_n_i) begin
      ptr_r <= link_addr_i;
    end else if (st_r == BFCFG_BURST && !chip_en_n_i) begin
      ptr_r <= ptr_nxt;
    end
  end

  assign busy_l = st_r != BFCFG_IDLE;

  // falling edge copies, half a link cycle behind the rising engine
  always_ff @(negedge link_clk_i) begin
    if (lrst) begin
      rdy_f_r <= 1'b0;
      dv_f_r <= 1'b0;
      ptr_f_r <= '0;
    end else begin
      rdy_f_r <= rdy_r;
      dv_f_r <= dv_r;
      ptr_f_r <= ptr_r;
    end
  end

  always_comb begin
    if (lcfg_r[MODE_BIT]) begin
      rdy_o = 1'b1;
      data_valid_o = 1'b0;
      word_addr_o = ptr_r;
    end else if (lcfg_r[EDGE_BIT]) begin
      rdy_o = rdy_r;
      data_valid_o = dv_r;
      word_addr_o = ptr_r;
    end else begin
      rdy_o = rdy_f_r;
      data_valid_o = dv_f_r;
      word_addr_o = ptr_f_r;
    end
  end
endmodule // bfcfg_top
`default_nettype wire

// File: dv/bfcfg_checker.sv
// bfcfg_checker: port assertions for bfcfg_top
// assumes: bound to bfcfg_top, rst_i resets both clock domains
`timescale 1ns/1ps
`default_nettype none
module bfcfg_checker #(
  parameter int ADDR_W = 22
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              link_clk_i,
  input wire logic              chip_en_n_i,
  input wire logic              addr_valid_strobe_n_i,
  input wire logic              rdy_o,
  input wire logic              data_valid_o,
  input wire logic [ADDR_W-1:0] word_addr_o
);
  a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o) else $error("ack late");
  a_write_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (wb_ack_o && wb_we_i) |-> wb_dat_o == 32'h0) else $error("write data not zero");
  a_rdy_dv: assert property (@(posedge link_clk_i) disable iff (rst_i)
    data_valid_o |-> rdy_o) else $error("data without ready");
  a_dv_first: assert property (@(posedge link_clk_i) disable iff (rst_i)
    $rose(addr_valid_strobe_n_i) |-> !data_valid_o) else $error("data too early");
  a_dv_abort: assert property (@(posedge link_clk_i) disable iff (rst_i)
    !addr_valid_strobe_n_i |=> !data_valid_o) else $error("data during strobe");
  a_ce_drop: assert property (@(posedge link_clk_i) disable iff (rst_i)
    chip_en_n_i |=> !data_valid_o) else $error("data while deselected");
  a_addr_step: assert property (@(posedge link_clk_i) disable iff (rst_i)
    (data_valid_o && $past(data_valid_o)) |-> word_addr_o != $past(word_addr_o))
    else $error("burst address stuck");
endmodule // bfcfg_checker
bind bfcfg_top bfcfg_checker #(.ADDR_W(ADDR_W)) u_bfcfg_checker (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .link_clk_i(link_clk_i),
  .chip_en_n_i(chip_en_n_i), .addr_valid_strobe_n_i(addr_valid_strobe_n_i),
  .rdy_o(rdy_o), .data_valid_o(data_valid_o), .word_addr_o(word_addr_o));
`default_nettype wire

// File: dv/bfcfg_host_model.sv
// bfcfg_host_model: flash bus host issuing config commands and bursts
// assumes: link_clk_i free running, outputs feed the link ports
`timescale 1ns/1ps
`default_nettype none
module bfcfg_host_model #(
  parameter int ADDR_W = 22
) (
  input  wire logic              link_clk_i,
  input  wire logic              rdy_i,
  input  wire logic              data_valid_i,
  input  wire logic [ADDR_W-1:0] word_addr_i,
  output logic                   cfg_cmd_o,
  output logic      [7:0]        cfg_addr_o,
  output logic                   chip_en_n_o,
  output logic                   addr_valid_strobe_n_o,
  output logic      [ADDR_W-1:0] link_addr_o
);
  initial begin
    {cfg_cmd_o, chip_en_n_o, addr_valid_strobe_n_o} = 3'b011;
    cfg_addr_o = 8'h00;
    link_addr_o = '0;
  end
  // released address lines show the inverse
  task automatic cfg(input logic [7:0] c);
    @(posedge link_clk_i);
    cfg_cmd_o <= 1'b1;
    cfg_addr_o <= c;
    @(posedge link_clk_i);
    cfg_cmd_o <= 1'b0;
    cfg_addr_o <= ~c;
  endtask
  task automatic burst(input logic [ADDR_W-1:0] a, input logic fall, input int n,
                       output int fdv, output logic rq[$], output logic [ADDR_W-1:0] q[$]);
    fdv = 0;
    rq = {};
    q = {};
    @(posedge link_clk_i);
    chip_en_n_o <= 1'b0;
    addr_valid_strobe_n_o <= 1'b0;
    link_addr_o <= a;
    @(posedge link_clk_i);
    addr_valid_strobe_n_o <= 1'b1;
    link_addr_o <= ~a;
    for (int k = 1; k < 30 && q.size() < n; k++) begin
      @(posedge link_clk_i);
      if (fall) @(negedge link_clk_i);
      rq.push_back(rdy_i);
      if (data_valid_i === 1'b1) begin
        if (fdv == 0) fdv = k;
        q.push_back(word_addr_i);
      end
    end
    @(posedge link_clk_i);
    chip_en_n_o <= 1'b1;
  endtask
endmodule // bfcfg_host_model
`default_nettype wire

// File: dv/testbench.sv
// testbench: random configurations and bursts through bfcfg_top
// assumes: host model on the link side, bench as wishbone master
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module testbench import bfcfg_pkg::*;;
  logic        clk_i, rst_i, link_clk_i, cyc, stb, we, ack, cmd, ce_n, avs_n, rdy, dv;
  logic [7:0]  adr, caddr, c;
  logic [3:0]  sel;
  logic [31:0] dat, dat_o, r;
  logic [21:0] la, wa, a;
  logic [15:0] seed;
  logic        rq[$];
  logic [21:0] q[$];
  int          bad_count, check_count, fdv, lat, bl;
  bfcfg_top u_bfcfg_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .link_clk_i(link_clk_i), .cfg_cmd_i(cmd), .cfg_addr_i(caddr),
    .chip_en_n_i(ce_n), .addr_valid_strobe_n_i(avs_n), .link_addr_i(la), .rdy_o(rdy),
    .data_valid_o(dv), .word_addr_o(wa));
  bfcfg_host_model u_bfcfg_host_model (.link_clk_i(link_clk_i), .rdy_i(rdy),
    .data_valid_i(dv), .word_addr_i(wa), .cfg_cmd_o(cmd), .cfg_addr_o(caddr),
    .chip_en_n_o(ce_n), .addr_valid_strobe_n_o(avs_n), .link_addr_o(la));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #13;
    forever #32 link_clk_i = ~link_clk_i;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // wrap modes keep upper bits, continuous counts on
  function automatic logic [21:0] exp_addr(input logic [21:0] s, input int b, input int i);
    logic [21:0] mk;
    mk = (b == 0) ? '1 : 22'((1 << (b + 2)) - 1);
    return (s & ~mk) | ((s + 22'(i)) & mk);
  endfunction
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wb_io(input logic w, input logic [7:0] ad, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] rd);
    int t;
    t = 0;
    @(posedge clk_i);
    {cyc, stb, we} <= {2'b11, w};
    adr <= ad;
    dat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack !== 1'b1 && t < 50);
    rd = dat_o;
    {cyc, stb} <= 2'b00;
    if (t >= 50) bad_count++;
  endtask
  task automatic cfg_link(input logic [7:0] v);
    int t;
    t = 0;
    u_bfcfg_host_model.cfg(v);
    do begin
      wb_io(1'b0, OFS_CFG, 32'h0, 4'hf, r);
      t++;
    end while (r[7:0] !== v && t < 20);
    `CHK(r[7:0], v)
    do begin
      wb_io(1'b0, OFS_STAT, 32'h0, 4'hf, r);
      t++;
    end while (r[STAT_PEND] !== 1'b0 && t < 40);
    `CHK(r[STAT_PEND], 1'b0)
    `CHK(r[STAT_SYNC], !v[7])
    `CHK(r[STAT_RSVD], v[2:1] == 2'h3)
    repeat (10) @(posedge clk_i);
  endtask
  task automatic async_burst;
    u_bfcfg_host_model.burst(22'h15, 1'b0, 4, fdv, rq, q);
    `CHK(fdv, 0)
    foreach (rq[i]) `CHK(rq[i], 1'b1)
  endtask
  initial begin
    {rst_i, cyc, stb, we, sel, adr, dat} = {4'b1000, 4'h0, 8'h00, 32'h0};
    seed = 16'hf40f;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_io(1'b0, OFS_CFG, 32'h0, 4'hf, r);
    `CHK(r[7:0], CFG_RST)
    wb_io(1'b1, 8'h08, 32'hff, 4'hf, r);
    wb_io(1'b0, 8'h08, 32'h0, 4'hf, r);
    `CHK(r, 32'h0)
    repeat (4) @(posedge link_clk_i);
    async_burst();
    for (int m = 0; m < 24; m++) begin
      seed = lfsr(seed);
      lat = m % 6;
      bl = m / 6;
      c = {1'b0, seed[0], seed[1], 2'(bl), 3'(lat)};
      cfg_link(c);
      a = {seed, seed[5:0]};
      u_bfcfg_host_model.burst(a, !c[EDGE_BIT], 10, fdv, rq, q);
      `CHK(fdv, lat + 2)
      `CHK(rq[fdv - 2], (!c[RDY_BIT] && lat != 0))
      foreach (q[i]) `CHK(q[i], exp_addr(a, bl, i))
    end
    // reserved code only from software, never from the link host
    wb_io(1'b1, OFS_CFG, 32'h06, 4'h1, r);
    `CHK(r, 32'h0)
    wb_io(1'b0, OFS_STAT, 32'h0, 4'hf, r);
    `CHK(r[STAT_RSVD], 1'b1)
    wb_io(1'b1, OFS_CFG, 32'h3a, 4'he, r);
    wb_io(1'b0, OFS_CFG, 32'h0, 4'hf, r);
    `CHK(r[7:0], 8'h06)
    wb_io(1'b1, OFS_CFG, 32'h3a, 4'h1, r);
    wb_io(1'b0, OFS_CFG, 32'h0, 4'hf, r);
    `CHK(r[7:0], 8'h3a)
    rst_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_io(1'b0, OFS_CFG, 32'h0, 4'hf, r);
    `CHK(r[7:0], CFG_RST)
    repeat (4) @(posedge link_clk_i);
    async_burst();
    end_sim();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    end_sim();
  end
endmodule // testbench
`default_nettype wire
